/* otp_asserts.sv */
/*
 * link checker for the otp controller and device pair: answer timing,
 * refusal of reads while partitions are busy, identifier contents.
 * assumes tb wires the interface signals in by name, one clock domain.
 */
`timescale 1ns/1ps
module otp_asserts
    import otp_pkg::*;
#(
    parameter logic [63:0] FACTORY_ID = 64'h0
) (
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    // link
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [1:0]  cmd_part,
    input  wire logic [7:0]  cmd_addr,
    input  wire logic [15:0] cmd_data,
    input  wire logic        rsp_valid,
    input  wire logic [15:0] rsp_data,
    input  wire logic        rsp_refused,
    input  wire logic [3:0]  part_busy
);
    logic [3:0] idm_q;
    logic       rd;
    logic       idr;
    logic       setup;
    logic       setup_q;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // partition 0 also carries program data, so its tracked mode is not used
    assign rd  = cmd_valid && !cmd_write;
    assign idr = rd && cmd_part != 2'h0 && idm_q[cmd_part] && cmd_addr >= ID_LOCK_WORD
                 && cmd_addr <= 8'h88;
    // program setup only; the data word after it may carry any low byte
    assign setup = cmd_valid && cmd_write && cmd_data[7:0] == CMD_OTP_PROGRAM && !setup_q;
    // any other command drops tracking, which only makes the check weaker
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            idm_q   <= 4'h0;
            setup_q <= 1'b0;
        end else begin
            setup_q <= setup;
            if (cmd_valid && cmd_write) begin
                idm_q[cmd_part] <= (cmd_data[7:0] == CMD_READ_IDENT);
            end
        end
    end
    property p_answer; rd |=> rsp_valid; endproperty
    a_answer: assert property (p_answer) else $error("read got no answer");
    property p_no_stray; rsp_valid |-> $past(rd); endproperty
    a_no_stray: assert property (p_no_stray) else $error("answer without read");
    property p_busy_part; rd && part_busy[cmd_part] |=> rsp_valid && rsp_refused; endproperty
    a_busy_part: assert property (p_busy_part) else $error("busy partition read");
    property p_main_ok;
        rd && cmd_part != 2'h0 && !part_busy[cmd_part] && !part_busy[0] |=> !rsp_refused;
    endproperty
    a_main_ok: assert property (p_main_ok) else $error("main partition refused");
    property p_param_busy; idr && part_busy[0] |=> rsp_refused; endproperty
    a_param_busy: assert property (p_param_busy) else $error("otp read in param busy");
    property p_lock_bit; idr && cmd_addr == ID_LOCK_WORD |=> rsp_refused || !rsp_data[0];
    endproperty
    a_lock_bit: assert property (p_lock_bit) else $error("factory lock bit set");
    property p_factory;
        idr && cmd_addr == ID_OTP_BASE |=> rsp_refused || rsp_data == FACTORY_ID[15:0];
    endproperty
    a_factory: assert property (p_factory) else $error("factory word wrong");
    property p_prog_param;
        setup |=> cmd_valid && cmd_write && cmd_part == 2'h0;
    endproperty
    a_prog_param: assert property (p_prog_param) else $error("program data misrouted");
    // main scenarios reached
    c_param_busy: cover property (idr && part_busy[0]);
    c_refused: cover property (rsp_valid && rsp_refused);
    c_program: cover property (cmd_valid && cmd_write && cmd_data[7:0] == CMD_OTP_PROGRAM);
    c_array_cmd: cover property (cmd_valid && cmd_write && cmd_data[7:0] == CMD_READ_ARRAY);
endmodule : otp_asserts

/* otp_device.sv */
/*
 * otp protection register device end: identifier reads, 16-bit user
 * programming, lock word, status flags and simultaneous-operation refusal.
 * assumes the host keeps the parameter-partition access restrictions.
 */
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module otp_device #(
    parameter logic [63:0] FACTORY_ID = 64'h0123_4567_89ab_cdef // arbitrary
) (
    // clock and reset
    input  wire logic     clk_sys_in,
    input  wire logic     rst_n_in,
    // programming supply comparator, asynchronous pin
    input  wire logic     supply_low_in,
    // link
    otp_link_if.device    link
);
    import otp_pkg::*;

    typedef enum {ST_ARRAY, ST_IDENT, ST_STATUS, ST_PROG_SETUP} mode_t;

    mode_t       mode_q [NUM_PARTS];
    logic [15:0] user_q [OTP_WORDS-FACTORY_WORDS];
    logic [15:0] lock_q;
    logic [7:0]  status_q;
    logic        prog_busy_q;
    logic [7:0]  prog_cnt_q;
    logic        sup_meta_q;
    logic        sup_q;
    logic        rsp_valid_q;
    logic        rsp_refused_q;
    logic [15:0] rsp_data_q;

    // supply pin crosses into the clock domain through two stages
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sup_meta_q <= 1'b0;
            sup_q      <= 1'b0;
        end else begin
            sup_meta_q <= supply_low_in;
            sup_q      <= sup_meta_q;
        end
    end

    // decode of the current request
    wire        is_wr     = link.cmd_valid && link.cmd_write;
    wire        is_rd     = link.cmd_valid && !link.cmd_write;
    wire [1:0]  part      = link.cmd_part;
    wire [7:0]  addr      = link.cmd_addr;
    wire        in_otp    = addr >= ID_LOCK_WORD && addr < ID_OTP_BASE + 8'(OTP_WORDS);
    wire        in_user   = addr >= ID_OTP_BASE + 8'(FACTORY_WORDS) &&
                            addr < ID_OTP_BASE + 8'(OTP_WORDS);
    wire [2:0]  word_idx  = 3'(addr - ID_OTP_BASE);
    wire [1:0]  user_idx  = word_idx[1:0];
    wire        user_lock = !lock_q[1];
    wire        param_busy = link.part_busy[PARAM_PART];
    // main partition busy elsewhere is fine; the busy one itself is not
    wire        part_busy = link.part_busy[part];
    wire        prog_setup = mode_q[part] == ST_PROG_SETUP;

    // read refusal: own busy partition, parameter busy on otp ident reads, parameter during otp program
    wire rd_refuse = part_busy ||
                     (param_busy && mode_q[part] == ST_IDENT && in_otp) ||
                     (prog_busy_q && part == 2'(PARAM_PART));

    // word read from identifier space
    function automatic logic [15:0] otp_word(input logic [7:0] a, input logic [15:0] lk,
                                             input logic [63:0] fac,
                                             input logic [15:0] u0, input logic [15:0] u1,
                                             input logic [15:0] u2, input logic [15:0] u3);
        logic [2:0] i;
        i = 3'(a - ID_OTP_BASE);
        if (a == ID_LOCK_WORD) return lk;
        case (i)
            3'd0: return fac[15:0];
            3'd1: return fac[31:16];
            3'd2: return fac[47:32];
            3'd3: return fac[63:48];
            3'd4: return u0;
            3'd5: return u1;
            3'd6: return u2;
            default: return u3;
        endcase
    endfunction : otp_word

    wire [15:0] id_word = otp_word(addr, lock_q, FACTORY_ID,
                                   user_q[0], user_q[1], user_q[2], user_q[3]);
    wire [15:0] rd_word = mode_q[part] == ST_IDENT ?
                          (in_otp ? id_word : 16'h0000) :
                          (mode_q[part] == ST_ARRAY ? 16'hffff : {8'h00, status_q});

    // program data phase outcome
    wire data_phase  = is_wr && prog_setup;
    wire bad_addr    = data_phase && !in_otp;
    wire to_lock     = data_phase && addr == ID_LOCK_WORD;
    wire locked_hit  = data_phase && in_otp && !to_lock &&
                       (!in_user || user_lock);
    wire lock_locked = to_lock && user_lock;
    wire supply_bad  = data_phase && sup_q;
    wire prog_ok     = data_phase && !sup_q && in_otp && !locked_hit && !lock_locked;

    // per-partition mode machine
    for (genvar p = 0; p < NUM_PARTS; p++) begin : g_mode
        always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                mode_q[p] <= ST_ARRAY;
            end else if (is_wr && part == 2'(p)) begin
                if (prog_setup) begin
                    mode_q[p] <= ST_STATUS;
                end else begin
                    case (link.cmd_data[7:0])
                        CMD_READ_ARRAY:  mode_q[p] <= ST_ARRAY;
                        CMD_READ_IDENT:  mode_q[p] <= ST_IDENT;
                        CMD_READ_STATUS: mode_q[p] <= ST_STATUS;
                        CMD_OTP_PROGRAM: mode_q[p] <= ST_PROG_SETUP;
                        default:         mode_q[p] <= mode_q[p];
                    endcase
                end
            end
        end
    end

    // user words: programming only clears bits, so ones never return
    for (genvar w = 0; w < OTP_WORDS - FACTORY_WORDS; w++) begin : g_user
        always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                user_q[w] <= 16'hffff;
            end else if (prog_ok && in_user && user_idx == 2'(w)) begin
                user_q[w] <= user_q[w] & link.cmd_data;
            end
        end
    end

    // lock word: factory bit stays zero, user bit cleared by fffd
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lock_q <= LOCK_RESET;
        end else if (prog_ok && to_lock) begin
            lock_q <= lock_q & link.cmd_data & 16'hfffe;
        end
    end

    // status flags: errors sticky until clear command; ready drops while programming
    wire clr_status = is_wr && !prog_setup && link.cmd_data[7:0] == CMD_CLEAR_STATUS;
    logic [7:0] status_d;
    always_comb begin
        status_d = clr_status ? 8'h00 : status_q;
        if (bad_addr) status_d[SR_PROG_ERR] = 1'b1;
        if (locked_hit || lock_locked) begin
            status_d[SR_PROG_ERR] = 1'b1;
            status_d[SR_SEQ_ERR]  = 1'b1;
        end
        if (supply_bad) status_d[SR_SUPPLY] = 1'b1;
        status_d[SR_READY] = !(prog_busy_q || prog_ok);
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_q <= 8'h80;
        end else begin
            status_q <= status_d;
        end
    end

    // program busy timer
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prog_busy_q <= 1'b0;
            prog_cnt_q  <= 8'h00;
        end else if (prog_ok) begin
            prog_busy_q <= 1'b1;
            prog_cnt_q  <= 8'(PROG_CYCLES);
        end else if (prog_busy_q) begin
            prog_cnt_q  <= prog_cnt_q - 8'h01;
            prog_busy_q <= prog_cnt_q != 8'h01;
        end
    end

    // read response registered one cycle after the request
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rsp_valid_q   <= 1'b0;
            rsp_refused_q <= 1'b0;
            rsp_data_q    <= 16'h0000;
        end else begin
            rsp_valid_q   <= is_rd;
            rsp_refused_q <= is_rd && rd_refuse;
            rsp_data_q    <= (is_rd && !rd_refuse) ? rd_word : 16'h0000;
        end
    end

    assign link.rsp_valid   = rsp_valid_q;
    assign link.rsp_refused = rsp_refused_q;
    assign link.rsp_data    = rsp_data_q;
endmodule : otp_device

/* otp_host.sv */
/*
 * controller end: ahb-lite slave of software registers that issues one or two
 * link commands per operation and returns read data, with sticky interrupt status.
 * assumes one master on the bus and the device on the same clock.
 */
`timescale 1ns/1ps
module otp_host (
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    // ahb-lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // partition activity seen by the device
    input  wire logic [3:0]  part_busy_in,
    // interrupt
    output logic             irq_out,
    // link
    otp_link_if.host         link
);
    import otp_pkg::*;

    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic [31:0] rdata_q;
    logic        ready_q;
    logic        cmd_valid_q;
    logic        cmd_write_q;
    logic [1:0]  cmd_part_q;
    logic [7:0]  cmd_addr_q;
    logic [15:0] cmd_data_q;
    logic [1:0]  part_q;
    logic [7:0]  addr_q;
    logic [15:0] wdata_q;
    logic [15:0] link_rdata_q;
    logic        refused_q;
    logic        second_q;
    logic [2:0]  irq_st_q;
    logic [2:0]  irq_msk_q;
    logic        irq_q;
    logic [3:0]  busy_q;

    // bus decode
    wire        addr_ph  = hsel_in && hready_in && htrans_in[1];
    wire        wr_do    = wr_pend_q;
    wire        go       = wr_do && wr_addr_q == REG_CTRL;
    wire        op_busy  = cmd_valid_q || second_q;
    wire [2:0]  op       = hwdata_in[2:0];
    wire        want_rd  = op == OP_READ_ID || op == OP_READ_STATUS;
    wire [2:0]  ev       = {link.rsp_valid && link.rsp_refused,
                            link.rsp_valid && !link.rsp_refused,
                            cmd_valid_q && cmd_write_q && !second_q};

    // command codes of each operation; program takes two link writes
    function automatic logic [7:0] op_code(input logic [2:0] o);
        case (o)
            OP_READ_ID:     return CMD_READ_IDENT;
            OP_READ_ARRAY:  return CMD_READ_ARRAY;
            OP_PROGRAM:     return CMD_OTP_PROGRAM;
            OP_READ_STATUS: return CMD_READ_STATUS;
            default:        return CMD_CLEAR_STATUS;
        endcase
    endfunction : op_code

    // bus pipeline and register writes
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            part_q    <= 2'b00;
            addr_q    <= 8'h00;
            wdata_q   <= 16'h0000;
            irq_msk_q <= 3'b000;
        end else begin
            wr_pend_q <= addr_ph && hwrite_in;
            wr_addr_q <= haddr_in[7:0];
            if (wr_do && wr_addr_q == REG_ADDR) begin
                addr_q <= hwdata_in[7:0];
                part_q <= hwdata_in[9:8];
            end
            if (wr_do && wr_addr_q == REG_WDATA) wdata_q <= hwdata_in[15:0];
            if (wr_do && wr_addr_q == REG_IRQ_MSK) irq_msk_q <= hwdata_in[2:0];
        end
    end

    // link command sequencing; a second write follows a program setup
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmd_valid_q <= 1'b0;
            cmd_write_q <= 1'b0;
            cmd_part_q  <= 2'b00;
            cmd_addr_q  <= 8'h00;
            cmd_data_q  <= 16'h0000;
            second_q    <= 1'b0;
        end else if (go && !op_busy && op != OP_NONE) begin
            cmd_valid_q <= 1'b1;
            cmd_write_q <= 1'b1;
            // programming setup always aimed at the parameter partition
            cmd_part_q  <= op == OP_PROGRAM ? 2'(PARAM_PART) : part_q;
            cmd_addr_q  <= addr_q;
            cmd_data_q  <= {8'h00, op_code(op)};
            second_q    <= op == OP_PROGRAM || want_rd;
        end else if (second_q) begin
            // for reads the follow-up is the read itself; for program the data
            cmd_valid_q <= 1'b1;
            cmd_write_q <= cmd_data_q[7:0] == CMD_OTP_PROGRAM;
            cmd_data_q  <= wdata_q;
            second_q    <= 1'b0;
        end else begin
            cmd_valid_q <= 1'b0;
        end
    end

    // read result, refusal, interrupt status with set winning over clear
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            link_rdata_q <= 16'h0000;
            refused_q    <= 1'b0;
            irq_st_q     <= 3'b000;
            irq_q        <= 1'b0;
            busy_q       <= 4'h0;
        end else begin
            busy_q <= part_busy_in;
            if (link.rsp_valid) begin
                link_rdata_q <= link.rsp_data;
                refused_q    <= link.rsp_refused;
            end
            irq_st_q <= (irq_st_q & ~((wr_do && wr_addr_q == REG_IRQ_ST) ?
                         hwdata_in[2:0] : 3'b000)) | ev;
            irq_q    <= |(irq_st_q & irq_msk_q);
        end
    end

    // read data selection and registered answer
    wire [31:0] rd_mux = haddr_in[7:0] == REG_CTRL    ? {31'h0, op_busy} :
                         haddr_in[7:0] == REG_ADDR    ? {22'h0, part_q, addr_q} :
                         haddr_in[7:0] == REG_WDATA   ? {16'h0, wdata_q} :
                         haddr_in[7:0] == REG_RDATA   ? {16'h0, link_rdata_q} :
                         haddr_in[7:0] == REG_IRQ_ST  ? {29'h0, irq_st_q} :
                         haddr_in[7:0] == REG_IRQ_MSK ? {29'h0, irq_msk_q} :
                         haddr_in[7:0] == REG_LSTAT   ? {27'h0, refused_q, busy_q} :
                         32'h0000_0000;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b1;
        end else begin
            if (addr_ph && !hwrite_in) rdata_q <= rd_mux;
        end
    end

    assign hrdata_out     = rdata_q;
    assign hreadyout_out  = ready_q;
    assign hresp_out      = 1'b0;
    assign irq_out        = irq_q;
    assign link.cmd_valid = cmd_valid_q;
    assign link.cmd_write = cmd_write_q;
    assign link.cmd_part  = cmd_part_q;
    assign link.cmd_addr  = cmd_addr_q;
    assign link.cmd_data  = cmd_data_q;
    assign link.part_busy = busy_q;
endmodule : otp_host

/* otp_link_if.sv */
/*
 * link between controller and otp device: one command strobe per cycle,
 * read data returned one cycle later on the same clock.
 * assumes both ends share clk and reset.
 */
`timescale 1ns/1ps
interface otp_link_if;
    localparam int NP = 4;
    logic        cmd_valid;
    logic        cmd_write;
    logic [1:0]  cmd_part;
    logic [7:0]  cmd_addr;
    logic [15:0] cmd_data;
    logic        rsp_valid;
    logic [15:0] rsp_data;
    logic        rsp_refused;
    logic [NP-1:0] part_busy;
    modport device (input cmd_valid, cmd_write, cmd_part, cmd_addr, cmd_data,
                    input part_busy, output rsp_valid, rsp_data, rsp_refused);
    modport host   (output cmd_valid, cmd_write, cmd_part, cmd_addr, cmd_data,
                    output part_busy, input rsp_valid, rsp_data, rsp_refused);
endinterface : otp_link_if

/* otp_pkg.sv */
/*
 * shared constants for the otp protection register link: command codes,
 * identifier word offsets, status flag positions, register map of the
 * controller's own software registers.
 * assumes a single clock domain and one device on the link.
 */
package otp_pkg;
    // link commands
    localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
    localparam logic [7:0] CMD_READ_IDENT   = 8'h90;
    localparam logic [7:0] CMD_OTP_PROGRAM  = 8'hc0;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    // identifier space word offsets: lock word, then eight data words
    localparam logic [7:0] ID_LOCK_WORD     = 8'h80;
    localparam logic [7:0] ID_OTP_BASE      = 8'h81;
    localparam int         OTP_WORDS        = 8;
    localparam int         FACTORY_WORDS    = 4;
    localparam logic [15:0] LOCK_USER_VALUE = 16'hfffd;
    localparam logic [15:0] LOCK_RESET      = 16'hfffe;
    // status flag positions
    localparam int SR_READY    = 7;
    localparam int SR_SEQ_ERR  = 5;
    localparam int SR_PROG_ERR = 4;
    localparam int SR_SUPPLY   = 3;
    // partition activity
    localparam int NUM_PARTS   = 4;
    localparam int PARAM_PART  = 0;
    // program busy time
    localparam int PROG_NS     = 200;
    localparam int CLK_NS      = 25;
    localparam int PROG_CYCLES = (PROG_NS + CLK_NS - 1) / CLK_NS;
    // controller register map (byte offsets)
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_ADDR    = 8'h04;
    localparam logic [7:0] REG_WDATA   = 8'h08;
    localparam logic [7:0] REG_RDATA   = 8'h0c;
    localparam logic [7:0] REG_IRQ_ST  = 8'h10;
    localparam logic [7:0] REG_IRQ_MSK = 8'h14;
    localparam logic [7:0] REG_LSTAT   = 8'h18;
    // controller operations in ctrl[2:0]
    typedef enum logic [2:0] {
        OP_NONE, OP_READ_ID, OP_READ_ARRAY, OP_PROGRAM, OP_READ_STATUS, OP_CLEAR
    } op_t;
endpackage : otp_pkg

/* tb.sv */
/*
 * testbench: controller and device joined by the link, driven over ahb-lite.
 * assumes zero-wait slave; program busy time as in the package.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
    import otp_pkg::*;
    localparam logic [63:0] FID = 64'h0123_4567_89ab_cdef; // arbitrary
    typedef struct packed {
        logic [2:0] op; logic [1:0] part; logic [7:0] addr; logic [15:0] wd;
        logic [3:0] busy; logic sup; logic refd; logic [15:0] exp;
    } row_t;
    // op: 1 ident, 2 array, 3 program, 4 status, 5 clear
    row_t rows [28] = '{
        '{1, 1, 8'h80, 0, 0, 0, 0, 16'hfffe}, '{1, 2, 8'h81, 0, 0, 0, 0, 16'hcdef},
        '{1, 3, 8'h85, 0, 0, 0, 0, 16'hffff}, '{3, 0, 8'h85, 16'h1234, 0, 0, 0, 0},
        '{1, 1, 8'h85, 0, 0, 0, 0, 16'h1234}, '{3, 0, 8'h85, 16'hff0f, 0, 0, 0, 0},
        '{1, 2, 8'h85, 0, 0, 0, 0, 16'h1204}, '{4, 1, 8'h85, 0, 0, 0, 0, 16'h0080},
        '{3, 0, 8'h40, 0, 0, 0, 0, 0}, '{4, 2, 8'h00, 0, 0, 0, 0, 16'h0090},
        '{5, 1, 8'h00, 0, 0, 0, 0, 0}, '{3, 0, 8'h82, 0, 0, 0, 0, 0},
        '{4, 3, 8'h00, 0, 0, 0, 0, 16'h00b0}, '{1, 1, 8'h82, 0, 0, 0, 0, 16'h89ab},
        '{5, 1, 8'h00, 0, 0, 0, 0, 0}, '{3, 0, 8'h87, 0, 0, 1, 0, 0},
        '{4, 1, 8'h00, 0, 0, 1, 0, 16'h0088}, '{5, 1, 8'h00, 0, 0, 0, 0, 0},
        '{1, 2, 8'h87, 0, 0, 0, 0, 16'hffff}, '{1, 2, 8'h80, 0, 4'h2, 0, 0, 16'hfffe},
        '{1, 1, 8'h80, 0, 4'h2, 0, 1, 0}, '{1, 2, 8'h85, 0, 4'h1, 0, 1, 0},
        '{3, 0, 8'h80, 16'hfffd, 0, 0, 0, 0}, '{1, 3, 8'h80, 0, 0, 0, 0, 16'hfffc},
        '{3, 0, 8'h86, 0, 0, 0, 0, 0}, '{4, 1, 8'h00, 0, 0, 0, 0, 16'h00b0},
        '{1, 2, 8'h86, 0, 0, 0, 0, 16'hffff}, '{2, 1, 8'h00, 0, 0, 0, 0, 0}};
    logic        clk_sys_in = 0;
    logic        rst_n_in = 0;
    logic        hwrite = 0;
    logic        supply_low = 0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [3:0]  part_busy = 4'h0;
    logic [31:0] hrdata;
    logic [31:0] r;
    logic        hready;
    logic        hresp;
    logic        irq;
    int          n_fail = 0;
    int          checks = 0;
    // free-running system clock
    always #12.5 clk_sys_in = ~clk_sys_in;
    otp_link_if link ();
    otp_host otp_host_inst (.clk_sys_in, .rst_n_in, .hsel_in(1'b1), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .part_busy_in(part_busy), .irq_out(irq), .link(link));
    otp_device #(.FACTORY_ID(FID)) otp_device_inst (.clk_sys_in, .rst_n_in,
        .supply_low_in(supply_low), .link(link));
    otp_asserts #(.FACTORY_ID(FID)) otp_asserts_inst (.clk_sys_in, .rst_n_in,
        .cmd_valid(link.cmd_valid), .cmd_write(link.cmd_write), .cmd_part(link.cmd_part),
        .cmd_addr(link.cmd_addr), .cmd_data(link.cmd_data), .rsp_valid(link.rsp_valid),
        .rsp_data(link.rsp_data), .rsp_refused(link.rsp_refused), .part_busy(link.part_busy));
    task results;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    // next rising edge with hready high; a stuck bus ends the run
    task rdy;
        int i;
        i = 0;
        do begin @(posedge clk_sys_in); i++; end while (hready !== 1'b1 && i < 50);
        if (hready !== 1'b1) begin n_fail++; results(); end
    endtask : rdy
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        rdy();
        r = hrdata;
    endtask : bus
    // start an operation, then poll busy under a bound
    task go(input logic [2:0] op);
        int i;
        bus(1, REG_CTRL, {29'h0, op});
        i = 0;
        do begin bus(0, REG_CTRL, 32'h0); i++; end while (r[0] !== 1'b0 && i < 50);
        if (r[0] !== 1'b0) begin n_fail++; results(); end
    endtask : go
    task run(input int lo, input int hi);
        for (int i = lo; i < hi; i++) begin
            part_busy <= rows[i].busy;
            supply_low <= rows[i].sup;
            bus(1, REG_ADDR, {22'h0, rows[i].part, rows[i].addr});
            bus(1, REG_WDATA, {16'h0, rows[i].wd});
            go(rows[i].op);
            if (rows[i].op == 3'h1 || rows[i].op == 3'h4) begin
                bus(0, REG_LSTAT, 32'h0);
                `CHK(r[4], rows[i].refd)
                bus(0, REG_RDATA, 32'h0);
                if (!rows[i].refd) `CHK(r[15:0], rows[i].exp)
            end
            $display("row %0d done", i);
        end
    endtask : run
    initial begin
        repeat (10) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        run(0, 22);
        // status read at partition 0 right behind a program must be refused
        part_busy <= 4'h0;
        bus(1, REG_ADDR, 32'h88);
        bus(1, REG_WDATA, 32'hfff0);
        go(3'h3);
        go(3'h4);
        bus(0, REG_LSTAT, 32'h0);
        `CHK(r[4], 1'b1)
        repeat (12) @(posedge clk_sys_in);
        run(22, 28);
        // unmasked sticky status drives irq; write-one clears it
        bus(1, REG_IRQ_MSK, 32'h2);
        repeat (2) @(posedge clk_sys_in);
        `CHK(irq, 1'b1)
        bus(1, REG_IRQ_ST, 32'h7);
        repeat (2) @(posedge clk_sys_in);
        `CHK(irq, 1'b0)
        bus(0, 8'h1c, 32'h0);
        `CHK(r, 32'h0)
        `CHK(hresp, 1'b0)
        $display("irq test done");
        // second reset in mid-run clears the mask
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        bus(0, REG_IRQ_MSK, 32'h0);
        `CHK(r, 32'h0)
        $display("reset test done");
        results();
    end
endmodule : tb
